// ### verilog/acf_pkg.sv
// Constants, types and field layouts of the converter setup and output coder
package acf_pkg;

	localparam int ACF_DATA_W   = 12;
	localparam int ACF_REG_W    = 10;
	localparam int ACF_FIFO_D   = 32;

	// Address field of a bus write
	localparam int ACF_ADDR_HI  = 11;
	localparam int ACF_ADDR_LO  = 10;
	localparam logic [1:0] ACF_ADDR_CONV = 2'h0;
	localparam logic [1:0] ACF_ADDR_INTF = 2'h1;
	localparam logic [1:0] ACF_ADDR_RSV2 = 2'h2;
	localparam logic [1:0] ACF_ADDR_RSV3 = 2'h3;

	// Register reset values
	localparam logic [9:0] ACF_CONV_RST = 10'h020;
	localparam logic [9:0] ACF_INTF_RST = 10'h000;

	// Output codes of the coder
	localparam logic [11:0] ACF_CODE_TOP  = 12'hFFF;
	localparam logic [11:0] ACF_CODE_MID  = 12'h800;
	localparam logic [11:0] ACF_CODE_BOT  = 12'h000;
	localparam logic [11:0] ACF_CODE_FLIP = 12'h800;

	// Scan, differential and channel select codes, bits 7 down to 3
	localparam logic [4:0] ACF_SEL_POS  = 5'h00;
	localparam logic [4:0] ACF_SEL_NEG  = 5'h01;
	localparam logic [4:0] ACF_SEL_DIFF = 5'h04;
	localparam logic [4:0] ACF_SEL_SCAN = 5'h11;

	typedef enum logic [1:0] {
		ACF_TEST_NORMAL = 2'b00,
		ACF_TEST_UPPER  = 2'b01,
		ACF_TEST_MID    = 2'b10,
		ACF_TEST_LOWER  = 2'b11
	} acf_test_e;

	typedef enum logic [2:0] {
		ACF_IN_POS  = 3'b000,
		ACF_IN_NEG  = 3'b001,
		ACF_IN_DIFF = 3'b010,
		ACF_IN_SCAN = 3'b011,
		ACF_IN_RSVD = 3'b100
	} acf_input_e;

	// Bit 9 down to bit 0
	typedef struct packed {
		acf_test_e  test_sel;
		logic       scan_enable;
		logic [1:0] diff_count;
		logic [1:0] input_sel;
		logic       power_down;
		logic       reserved;
		logic       ref_external;
	} acf_conv_s;

	typedef struct packed {
		logic       readback_enable;
		logic       offset_ctrl;
		logic       coding_select;
		logic       bus_rw_style;
		logic [3:0] reserved;
		logic       sync_gen_reset;
		logic       soft_reset;
	} acf_intf_s;

	typedef struct packed {
		logic       wr;
		logic       rd;
	} acf_strobe_s;

endpackage : acf_pkg

// ### verilog/acf_fifo.sv
// Sample FIFO with registered show-ahead read data
`timescale 1ns/1ns
module acf_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    wr_ptr_nxt;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW-1:0]    rd_ptr_nxt;
	logic [AW:0]      count_r;
	logic [AW:0]      count_nxt;
	logic [WIDTH-1:0] data_r;
	logic [WIDTH-1:0] data_nxt;
	logic             push;
	logic             pop;

	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = data_r;
	assign push      = in_valid && in_ready && !flush;
	assign pop       = out_valid && out_ready && !flush;

	always_comb begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		count_nxt  = count_r;
		if (flush) begin
			wr_ptr_nxt = '0;
			rd_ptr_nxt = '0;
			count_nxt  = '0;
		end else begin
			if (push)
				wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
		// Bypass a word written into the slot that becomes the head
		if (push && (wr_ptr_r == rd_ptr_nxt))
			data_nxt = in_data;
		else
			data_nxt = mem[rd_ptr_nxt];
	end

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
			data_r   <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r  <= count_nxt;
			data_r   <= data_nxt;
		end
	end

endmodule : acf_fifo

// ### verilog/acf_top.sv
// Setup registers, parallel data bus and output coding of the converter
// Operation
// - Each sample leaves as a 12-bit word, straight binary or twos complement.
// - Single-ended binary: upper reference FFF, midpoint 800, lower 000.
// - Single-ended twos complement: upper 7FF, midpoint 000, lower 800.
// - Differential binary: plus span FFF, zero 800, minus span 000.
// - Differential twos complement: plus span 7FF, zero 000, minus span 800.
// - Two ten-bit setup registers together set the operating mode.
// - Address 00 picks first register, 01 the second, others reserved.
// - First register bit 0 picks internal or external reference; bit 1 reserved.
// - Bit 2 powers down; bus reads and writes keep working meanwhile.
// - Bits 4..3 select input channel, bits 6..5 differential count.
// - First register resets to zero except bit 5, which resets to one.
// - Bit 7 enables automatic channel scan.
// - Bits 9..8 substitute an internal test voltage for the input.
// - Second register fields: readback, offset, coding, bus style, sync, reset.
// - Bits 7..3 decode positive, negative, differential, autoscan; rest reserved.
// - Test field: normal, upper reference, midpoint, lower reference.
// - Bit 0 of second register resets device until zero is written.
// - Bit 1 of second register resets the sync generator.
`timescale 1ns/1ns
module acf_top (
	input  wire logic        SYS_CLK,
	input  wire logic        RESET_N,
	input  wire logic        CS_N,
	input  wire logic        WR_N,
	input  wire logic        RD_N,
	input  wire logic [11:0] DATA_IN,
	output logic      [11:0] DATA_OUT,
	output logic             DATA_OE,
	input  wire logic        SAMPLE_VALID,
	input  wire logic [11:0] SAMPLE_CODE,
	output logic             SAMPLE_READY,
	output logic             DATA_AVAILABLE,
	output logic             REF_EXTERNAL,
	output logic             POWER_DOWN,
	output logic      [2:0]  INPUT_MODE,
	output logic             SCAN_ENABLE,
	output logic      [1:0]  TEST_MODE,
	output logic             OFFSET_CTRL,
	output logic             BUS_RW_STYLE,
	output logic             SYNC_GEN_RESET,
	output logic             DEVICE_IN_RESET
);

	// Setup registers
	acf_pkg::acf_conv_s   conv_r;
	acf_pkg::acf_conv_s   conv_nxt;
	acf_pkg::acf_intf_s   intf_r;
	acf_pkg::acf_intf_s   intf_nxt;

	// Bus strobe history and read data
	acf_pkg::acf_strobe_s act;
	acf_pkg::acf_strobe_s prev_r;
	acf_pkg::acf_strobe_s prev_nxt;
	logic [11:0]          data_out_r;
	logic [11:0]          data_out_nxt;
	logic                 pop_pend_r;
	logic                 pop_pend_nxt;

	// Decoded and derived values
	logic                 wr_take;
	logic                 rd_start;
	logic                 rd_end;
	logic [1:0]           wr_addr;
	logic [9:0]           wr_value;
	acf_pkg::acf_intf_s   wr_intf;
	acf_pkg::acf_input_e  input_mode;
	logic                 input_ok;
	logic                 in_hold;
	logic [11:0]          raw_code;
	logic [11:0]          coded;

	// FIFO handshake
	logic                 fifo_in_valid;
	logic                 fifo_in_ready;
	logic                 fifo_out_valid;
	logic                 fifo_out_ready;
	logic [11:0]          fifo_out_data;
	logic                 fifo_flush;

	// Bus style selects separate strobes or a direction line under chip select
	always_comb begin
		if (intf_r.bus_rw_style) begin
			act.wr = !CS_N && !WR_N;
			act.rd = !CS_N && WR_N;
		end else begin
			act.wr = !CS_N && !WR_N;
			act.rd = !CS_N && !RD_N;
		end
	end

	assign wr_take  = act.wr && !prev_r.wr;
	assign rd_start = act.rd && !prev_r.rd;
	assign rd_end   = !act.rd && prev_r.rd;

	// Address on the top two lines, value on the low ten
	assign wr_addr  = DATA_IN[acf_pkg::ACF_ADDR_HI:acf_pkg::ACF_ADDR_LO];
	assign wr_value = DATA_IN[acf_pkg::ACF_REG_W-1:0];
	assign wr_intf  = acf_pkg::acf_intf_s'(wr_value);
	assign in_hold  = intf_r.soft_reset;

	// Register write decode
	always_comb begin
		conv_nxt = conv_r;
		intf_nxt = intf_r;
		if (wr_take) begin
			unique case (wr_addr)
				acf_pkg::ACF_ADDR_CONV: begin
					// Writes stay open in power down, refused while held in reset
					if (!in_hold)
						conv_nxt = acf_pkg::acf_conv_s'(wr_value);
				end
				acf_pkg::ACF_ADDR_INTF: begin
					if (wr_intf.soft_reset) begin
						// Defaults restored, device held until bit 0 is cleared
						conv_nxt = acf_pkg::acf_conv_s'(acf_pkg::ACF_CONV_RST);
						intf_nxt = acf_pkg::acf_intf_s'(acf_pkg::ACF_INTF_RST);
						intf_nxt.soft_reset = 1'b1;
					end else begin
						intf_nxt = wr_intf;
					end
				end
				acf_pkg::ACF_ADDR_RSV2,
				acf_pkg::ACF_ADDR_RSV3: begin
					conv_nxt = conv_r;
					intf_nxt = intf_r;
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			conv_r <= acf_pkg::acf_conv_s'(acf_pkg::ACF_CONV_RST);
			intf_r <= acf_pkg::acf_intf_s'(acf_pkg::ACF_INTF_RST);
		end else begin
			conv_r <= conv_nxt;
			intf_r <= intf_nxt;
		end
	end

	// Input configuration decode of scan, differential and channel bits
	always_comb begin
		unique case ({conv_r.scan_enable, conv_r.diff_count,
			conv_r.input_sel})
			acf_pkg::ACF_SEL_POS:  input_mode = acf_pkg::ACF_IN_POS;
			acf_pkg::ACF_SEL_NEG:  input_mode = acf_pkg::ACF_IN_NEG;
			acf_pkg::ACF_SEL_DIFF: input_mode = acf_pkg::ACF_IN_DIFF;
			acf_pkg::ACF_SEL_SCAN: input_mode = acf_pkg::ACF_IN_SCAN;
			default:               input_mode = acf_pkg::ACF_IN_RSVD;
		endcase
	end

	assign input_ok = (input_mode != acf_pkg::ACF_IN_RSVD);

	// Test field puts a reference level in place of the input
	always_comb begin
		unique case (conv_r.test_sel)
			acf_pkg::ACF_TEST_NORMAL: raw_code = SAMPLE_CODE;
			acf_pkg::ACF_TEST_UPPER:  raw_code = acf_pkg::ACF_CODE_TOP;
			acf_pkg::ACF_TEST_MID:    raw_code = acf_pkg::ACF_CODE_MID;
			acf_pkg::ACF_TEST_LOWER:  raw_code = acf_pkg::ACF_CODE_BOT;
		endcase
	end

	// Raw code is offset binary for single-ended and differential alike;
	// twos complement only inverts the top bit
	always_comb begin
		if (intf_r.coding_select)
			coded = raw_code ^ acf_pkg::ACF_CODE_FLIP;
		else
			coded = raw_code;
	end

	// Samples enter only while active, configured and not held in reset
	assign fifo_in_valid = SAMPLE_VALID && input_ok && !conv_r.power_down
		&& !in_hold;
	assign SAMPLE_READY  = fifo_in_ready && input_ok && !conv_r.power_down
		&& !in_hold;
	assign fifo_flush    = in_hold;
	assign fifo_out_ready = rd_end && pop_pend_r;

	acf_fifo #(
		.WIDTH (acf_pkg::ACF_DATA_W),
		.DEPTH (acf_pkg::ACF_FIFO_D)
	) u_fifo (
		.clk       (SYS_CLK),
		.rst_n     (RESET_N),
		.flush     (fifo_flush),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (coded),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// Read data latched when a read starts; the sample leaves when it ends
	always_comb begin
		prev_nxt     = act;
		data_out_nxt = data_out_r;
		pop_pend_nxt = pop_pend_r;
		if (rd_start) begin
			if (intf_r.readback_enable) begin
				data_out_nxt = {acf_pkg::ACF_ADDR_CONV, conv_r};
				pop_pend_nxt = 1'b0;
			end else begin
				data_out_nxt = fifo_out_data;
				pop_pend_nxt = fifo_out_valid;
			end
		end else if (rd_end) begin
			pop_pend_nxt = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			prev_r     <= '{wr: 1'b0, rd: 1'b0};
			data_out_r <= acf_pkg::ACF_CODE_BOT;
			pop_pend_r <= 1'b0;
		end else begin
			prev_r     <= prev_nxt;
			data_out_r <= data_out_nxt;
			pop_pend_r <= pop_pend_nxt;
		end
	end

	// Drive the bus from the cycle after the read starts
	assign DATA_OUT = data_out_r;
	assign DATA_OE  = act.rd && prev_r.rd;

	assign DATA_AVAILABLE  = fifo_out_valid;
	assign REF_EXTERNAL    = conv_r.ref_external;
	assign POWER_DOWN      = conv_r.power_down;
	assign INPUT_MODE      = input_mode;
	assign SCAN_ENABLE     = conv_r.scan_enable;
	assign TEST_MODE       = conv_r.test_sel;
	assign OFFSET_CTRL     = intf_r.offset_ctrl;
	assign BUS_RW_STYLE    = intf_r.bus_rw_style;
	assign SYNC_GEN_RESET  = intf_r.sync_gen_reset;
	assign DEVICE_IN_RESET = intf_r.soft_reset;

endmodule : acf_top

// ### verif/acf_top_chk.sv
// Port assertions of the converter setup block
`timescale 1ns/1ns
module acf_top_chk (
	input wire logic        SYS_CLK,
	input wire logic        RESET_N,
	input wire logic        CS_N,
	input wire logic        WR_N,
	input wire logic        RD_N,
	input wire logic [11:0] DATA_IN,
	input wire logic        DATA_OE,
	input wire logic        SAMPLE_READY,
	input wire logic        POWER_DOWN,
	input wire logic [2:0]  INPUT_MODE,
	input wire logic        SCAN_ENABLE,
	input wire logic [1:0]  TEST_MODE,
	input wire logic        BUS_RW_STYLE,
	input wire logic        SYNC_GEN_RESET,
	input wire logic        DEVICE_IN_RESET
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	logic wr_q;
	wire  wr_act = !CS_N && !WR_N;
	wire  wr_new = wr_act && !wr_q;
	wire  wr_cv  = wr_new && DATA_IN[11:10] == 2'h0 && !DEVICE_IN_RESET;
	wire  wr_if  = wr_new && DATA_IN[11:10] == 2'h1;
	wire  rd_act = !CS_N && !RD_N && !BUS_RW_STYLE;
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) wr_q <= 1'b0;
		else wr_q <= wr_act;
	end
	function automatic logic [2:0] mode_of(logic [4:0] c);
		case (c)
			5'h00: return 3'h0;
			5'h01: return 3'h1;
			5'h04: return 3'h2;
			5'h11: return 3'h3;
			default: return 3'h4;
		endcase
	endfunction : mode_of
	a_reset_mode: assert property ($rose(RESET_N) |-> INPUT_MODE == 3'h2
		&& TEST_MODE == 2'h0 && !POWER_DOWN && !DEVICE_IN_RESET)
		else $error("setup not at reset value");
	a_conv_fields: assert property (wr_cv |=> TEST_MODE == $past(DATA_IN[9:8])
		&& POWER_DOWN == $past(DATA_IN[2]) && SCAN_ENABLE == $past(DATA_IN[7]))
		else $error("setup fields not loaded");
	a_mode_decode: assert property (wr_cv |=>
		INPUT_MODE == mode_of($past(DATA_IN[7:3])))
		else $error("input mode decode wrong");
	a_intf_fields: assert property (wr_if && !DATA_IN[0] |=> !DEVICE_IN_RESET
		&& SYNC_GEN_RESET == $past(DATA_IN[1])
		&& BUS_RW_STYLE == $past(DATA_IN[6]))
		else $error("interface fields not loaded");
	a_soft_reset: assert property (wr_if && DATA_IN[0] |=> DEVICE_IN_RESET
		&& INPUT_MODE == 3'h2 && TEST_MODE == 2'h0 && !POWER_DOWN)
		else $error("soft reset did not restore");
	a_rsvd_addr: assert property (wr_new && DATA_IN[11] |=> $stable(INPUT_MODE)
		&& $stable(TEST_MODE) && $stable(DEVICE_IN_RESET))
		else $error("reserved address changed a register");
	a_reset_lock: assert property (DEVICE_IN_RESET && wr_new
		&& DATA_IN[11:10] == 2'h0 |=> $stable(TEST_MODE) && $stable(POWER_DOWN))
		else $error("setup written during soft reset");
	a_ready_gate: assert property (POWER_DOWN || DEVICE_IN_RESET
		|| INPUT_MODE == 3'h4 |-> !SAMPLE_READY)
		else $error("sample taken while stopped");
	a_read_drive: assert property ($rose(rd_act) ##1 rd_act |-> DATA_OE)
		else $error("bus not driven on read");
	cover property (wr_cv);
	cover property (wr_if && DATA_IN[0]);
	cover property ($rose(rd_act) ##1 rd_act);
endmodule : acf_top_chk

bind acf_top acf_top_chk acf_top_chk_i (.SYS_CLK, .RESET_N, .CS_N, .WR_N,
	.RD_N, .DATA_IN, .DATA_OE, .SAMPLE_READY, .POWER_DOWN, .INPUT_MODE,
	.SCAN_ENABLE, .TEST_MODE, .BUS_RW_STYLE, .SYNC_GEN_RESET, .DEVICE_IN_RESET);

// ### verif/acf_host.sv
// Host processor model on the parallel setup and data bus
`timescale 1ns/1ns
module acf_host (
	input  wire logic        clk,
	input  wire logic [11:0] data_out,
	input  wire logic        data_oe,
	output logic             cs_n,
	output logic             wr_n,
	output logic             rd_n,
	output logic      [11:0] data_in
);
	initial begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		data_in = 12'h000;
	end
	task automatic wr(input logic [11:0] w);
		@(posedge clk);
		#1;
		cs_n = 1'b0;
		wr_n = 1'b0;
		data_in = w;
		@(posedge clk);
		#1;
		cs_n = 1'b1;
		wr_n = 1'b1;
		data_in = ~w;
		@(posedge clk);
	endtask : wr
	task automatic rd(output logic [11:0] d, output logic oe);
		@(posedge clk);
		#1;
		cs_n = 1'b0;
		rd_n = 1'b0;
		repeat (2) @(posedge clk);
		d = data_out;
		oe = data_oe;
		#1;
		cs_n = 1'b1;
		rd_n = 1'b1;
		@(posedge clk);
	endtask : rd
	// Read with chip select alone; a read only in direction-line style
	task automatic rd_cs(output logic [11:0] d, output logic oe);
		@(posedge clk);
		#1;
		cs_n = 1'b0;
		repeat (2) @(posedge clk);
		d = data_out;
		oe = data_oe;
		#1;
		cs_n = 1'b1;
		@(posedge clk);
	endtask : rd_cs
endmodule : acf_host

// ### verif/acf_top_bench.sv
// Self-checking bench of the converter setup block
`timescale 1ns/1ns
module acf_top_bench;
	logic SYS_CLK, RESET_N, SAMPLE_VALID;
	logic CS_N, WR_N, RD_N, DATA_OE, SAMPLE_READY, DATA_AVAILABLE;
	logic REF_EXTERNAL, POWER_DOWN, SCAN_ENABLE, OFFSET_CTRL, BUS_RW_STYLE;
	logic SYNC_GEN_RESET, DEVICE_IN_RESET, oe;
	logic [11:0] DATA_IN, DATA_OUT, d, SAMPLE_CODE;
	logic [2:0] INPUT_MODE;
	logic [1:0] TEST_MODE;
	int fail_count = 0, comparisons = 0;
	always #50 SYS_CLK = ~SYS_CLK;
	acf_top acf_top_i (.SYS_CLK, .RESET_N, .CS_N, .WR_N, .RD_N, .DATA_IN,
		.DATA_OUT, .DATA_OE, .SAMPLE_VALID, .SAMPLE_CODE, .SAMPLE_READY,
		.DATA_AVAILABLE, .REF_EXTERNAL, .POWER_DOWN, .INPUT_MODE,
		.SCAN_ENABLE, .TEST_MODE, .OFFSET_CTRL, .BUS_RW_STYLE,
		.SYNC_GEN_RESET, .DEVICE_IN_RESET);
	acf_host acf_host_i (.clk(SYS_CLK), .data_out(DATA_OUT),
		.data_oe(DATA_OE), .cs_n(CS_N), .wr_n(WR_N), .rd_n(RD_N),
		.data_in(DATA_IN));
	task automatic tally_and_finish();
		if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	function automatic logic [11:0] cv();
		return {4'h0, TEST_MODE, SCAN_ENABLE, POWER_DOWN, REF_EXTERNAL,
			INPUT_MODE};
	endfunction : cv
	task automatic push(input logic [11:0] c, input logic rdy);
		@(posedge SYS_CLK);
		#1;
		SAMPLE_VALID = 1'b1;
		SAMPLE_CODE = c;
		@(negedge SYS_CLK);
		check({11'h0, SAMPLE_READY}, {11'h0, rdy});
		@(posedge SYS_CLK);
		#1;
		SAMPLE_VALID = 1'b0;
	endtask : push
	task automatic t_modes();
		logic [4:0] c[5] = '{5'h00, 5'h01, 5'h04, 5'h11, 5'h02};
		check(cv(), 12'h002);
		for (int i = 0; i < 5; i++) begin
			acf_host_i.wr({4'h0, c[i], 3'h0});
			check(cv(), {6'h0, c[i][4], 2'h0, 3'(i)});
		end
	endtask : t_modes
	task automatic t_readback();
		acf_host_i.wr(12'h385);
		check(cv(), 12'h0FC);
		push(12'h123, 1'b0);
		acf_host_i.wr(12'h600);
		acf_host_i.rd(d, oe);
		check(d, 12'h385);
		acf_host_i.wr(12'h8AA);
		acf_host_i.wr(12'hCAA);
		acf_host_i.rd(d, oe);
		check(d, 12'h385);
	endtask : t_readback
	task automatic t_coding();
		logic [11:0] lvl[4] = '{12'h123, 12'hFFF, 12'h800, 12'h000};
		for (int cs = 0; cs < 2; cs++)
			for (int dm = 0; dm < 2; dm++)
				for (int t = 0; t < 4; t++) begin
					acf_host_i.wr({2'h1, 2'h0, 1'(cs), 7'h0});
					acf_host_i.wr({2'h0, 2'(t), 2'h0, 1'(dm), 5'h0});
					push(12'h123, 1'b1);
					acf_host_i.rd(d, oe);
					check({11'h0, oe}, 12'h001);
					check(d, lvl[t] ^ (cs ? 12'h800 : 12'h000));
				end
	endtask : t_coding
	task automatic t_fifo();
		acf_host_i.wr(12'h400);
		acf_host_i.wr(12'h000);
		for (int i = 0; i < 32; i++) push(12'(i * 3), 1'b1);
		push(12'h7, 1'b0);
		for (int i = 0; i < 32; i++) begin
			acf_host_i.rd(d, oe);
			check(d, 12'(i * 3));
		end
		@(negedge SYS_CLK);
		check({11'h0, DATA_AVAILABLE}, 12'h000);
	endtask : t_fifo
	task automatic t_soft();
		acf_host_i.wr(12'h401);
		check({11'h0, DEVICE_IN_RESET}, 12'h001);
		check(cv(), 12'h002);
		push(12'h5, 1'b0);
		acf_host_i.wr(12'h004);
		check(cv(), 12'h002);
		acf_host_i.wr(12'h402);
		check({DEVICE_IN_RESET, SYNC_GEN_RESET}, 12'h001);
	endtask : t_soft
	task automatic t_style();
		acf_host_i.rd_cs(d, oe);
		check({11'h0, oe}, 12'h000);
		acf_host_i.wr(12'h740);
		check({10'h0, OFFSET_CTRL, BUS_RW_STYLE}, 12'h003);
		acf_host_i.rd_cs(d, oe);
		check({11'h0, oe}, 12'h001);
		check(d, 12'h020);
		acf_host_i.wr(12'h400);
		check({10'h0, OFFSET_CTRL, BUS_RW_STYLE}, 12'h000);
	endtask : t_style
	initial begin
		#1000000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		SYS_CLK = 1'b0;
		RESET_N = 1'b0;
		SAMPLE_VALID = 1'b0;
		SAMPLE_CODE = 12'h000;
		repeat (20) @(posedge SYS_CLK);
		#1;
		RESET_N = 1'b1;
		t_modes();
		t_readback();
		t_coding();
		t_fifo();
		t_soft();
		t_style();
		tally_and_finish();
	end
endmodule : acf_top_bench
